// ### rtl/card_gate_consts.svh
// Named constants for the card signal gating block
`ifndef CARD_GATE_CONSTS_SVH
`define CARD_GATE_CONSTS_SVH

// Synchronised pin vector layout and reset image
`define SYN_W 6
`define SYN_RESET_CMD 5
`define SYN_SEL_A_N 4
`define SYN_SEL_B_N 3
`define SYN_CARD_PRESENCE_INPUT 2
`define SYN_CARD_PRESENCE_INPUT_N 1
`define SYN_VCC_OK 0
`define SYN_RESET_VAL 6'h1A

// Supply select codes, {select_a_n, select_b_n}
`define SEL_1V8 2'h0
`define SEL_5V0 2'h1
`define SEL_3V0 2'h2
`define SEL_NONE 2'h3

// Idle cycles after a data line is released, covers sync latency
`define LINE_GAP_CYCLES 2'h3
`define LINE_GAP_ZERO 2'h0
`define LINE_GAP_ONE 2'h1

// Both synchronised line levels at their pulled-up idle
`define LINE_SYNC_RESET 2'h3

`endif

// ### rtl/card_gate_pkg.sv
// Types for the card signal gating block
package card_gate_pkg;

  typedef enum logic [1:0] {
    VCC_1V8 = 2'b00,
    VCC_5V0 = 2'b01,
    VCC_3V0 = 2'b10,
    VCC_OFF = 2'b11
  } vcc_level_t;

  typedef enum logic [1:0] {
    SEQ_OFF = 2'b00,
    SEQ_RAMP = 2'b01,
    SEQ_ACTIVE = 2'b10,
    SEQ_FAULT = 2'b11
  } seq_state_t;

  typedef enum logic [1:0] {
    LINE_IDLE = 2'b00,
    LINE_HOST = 2'b01,
    LINE_CARD = 2'b10,
    LINE_GAP = 2'b11
  } line_state_t;

  // Open-drain drive: out level and enable
  typedef struct packed {
    logic o;
    logic oe;
  } od_drive_t;

  typedef struct packed {
    logic sel_a_n;
    logic sel_b_n;
  } supply_cmd_t;

endpackage : card_gate_pkg

// ### rtl/card_line_relay.sv
// Open-drain relay between one host data line and one card contact
`timescale 1ns/100ps
`include "card_gate_consts.svh"

module card_line_relay (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic enable,
  input wire logic host_i,
  input wire logic card_i,
  output card_gate_pkg::od_drive_t host_drv,
  output card_gate_pkg::od_drive_t card_drv
);

  logic [1:0] sync1_ff;
  logic [1:0] sync2_ff;
  logic host_low;
  logic card_low;
  card_gate_pkg::line_state_t state_ff;
  card_gate_pkg::line_state_t nxt_state;
  logic [1:0] gap_ff;
  logic host_oe_ff;
  logic card_oe_ff;

  // Lines idle high via pull-ups, so sync resets to high
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sync1_ff <= `LINE_SYNC_RESET;
      sync2_ff <= `LINE_SYNC_RESET;
    end else begin
      sync1_ff <= {host_i, card_i};
      sync2_ff <= sync1_ff;
    end
  end

  assign host_low = ~sync2_ff[1];
  assign card_low = ~sync2_ff[0];

  // First side to pull low owns the line until it lets go
  always_comb begin
    nxt_state = state_ff;
    unique case (state_ff)
      card_gate_pkg::LINE_IDLE: begin
        if (host_low) begin
          nxt_state = card_gate_pkg::LINE_HOST;
        end else if (card_low) begin
          nxt_state = card_gate_pkg::LINE_CARD;
        end
      end
      card_gate_pkg::LINE_HOST: begin
        if (!host_low) begin
          nxt_state = card_gate_pkg::LINE_GAP;
        end
      end
      card_gate_pkg::LINE_CARD: begin
        if (!card_low) begin
          nxt_state = card_gate_pkg::LINE_GAP;
        end
      end
      card_gate_pkg::LINE_GAP: begin
        if (gap_ff == `LINE_GAP_ONE) begin
          nxt_state = card_gate_pkg::LINE_IDLE;
        end
      end
    endcase
    if (!enable) begin
      nxt_state = card_gate_pkg::LINE_IDLE;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_ff <= card_gate_pkg::LINE_IDLE;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // Settle time so the released side is not echoed back
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      gap_ff <= `LINE_GAP_ZERO;
    end else if (nxt_state == card_gate_pkg::LINE_GAP &&
                 state_ff != card_gate_pkg::LINE_GAP) begin
      gap_ff <= `LINE_GAP_CYCLES;
    end else if (gap_ff != `LINE_GAP_ZERO) begin
      gap_ff <= gap_ff - `LINE_GAP_ONE;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      card_oe_ff <= 1'h0;
      host_oe_ff <= 1'h0;
    end else begin
      card_oe_ff <= (nxt_state == card_gate_pkg::LINE_HOST);
      host_oe_ff <= (nxt_state == card_gate_pkg::LINE_CARD);
    end
  end

  assign card_drv = '{o: 1'h0, oe: card_oe_ff};
  assign host_drv = '{o: 1'h0, oe: host_oe_ff};

endmodule : card_line_relay

// ### rtl/card_signal_gating.sv
// Smart-card contact gating, supply sequencing and data relays
`timescale 1ns/100ps
`include "card_gate_consts.svh"

// Notes on behaviour
// - Active card: reset contact copies host reset
// - Inactive or low supply: reset held low
// - Active card: clock contact copies clock source
// - Inactive or low supply: clock held low
// - High presence input means card present
// - Low presence input means card present
// - Sequencer alone switches card supply
// - Relay serial data, card contact idles high
// - Relay both aux lines, contacts idle high
// - Select code picks 1.8/5.0/3.0 V or off
// - Open-drain active-low interrupt for presence, fault
module card_signal_gating (
  input wire logic CLK,
  input wire logic RST_N,
  input wire logic CARD_CLOCK_SOURCE,
  input wire logic HOST_RESET_CMD,
  input wire logic SUPPLY_SELECT_A_N,
  input wire logic SUPPLY_SELECT_B_N,
  input wire logic CARD_PRESENCE_INPUT,
  input wire logic CARD_PRESENCE_INPUT_N,
  input wire logic VCC_GOOD,
  output logic VCC_ENABLE,
  output card_gate_pkg::vcc_level_t VCC_LEVEL,
  output logic READY,
  output logic CARD_RESET,
  output logic CARD_CLOCK,
  output logic IRQ_N_O,
  output logic IRQ_N_OE,
  input wire logic HOST_DATA_LINE_I,
  output logic HOST_DATA_LINE_O,
  output logic HOST_DATA_LINE_OE,
  input wire logic CARD_DATA_LINE_I,
  output logic CARD_DATA_LINE_O,
  output logic CARD_DATA_LINE_OE,
  input wire logic HOST_AUX_LINE_1_I,
  output logic HOST_AUX_LINE_1_O,
  output logic HOST_AUX_LINE_1_OE,
  input wire logic CARD_AUX_LINE_1_I,
  output logic CARD_AUX_LINE_1_O,
  output logic CARD_AUX_LINE_1_OE,
  input wire logic HOST_AUX_LINE_2_I,
  output logic HOST_AUX_LINE_2_O,
  output logic HOST_AUX_LINE_2_OE,
  input wire logic CARD_AUX_LINE_2_I,
  output logic CARD_AUX_LINE_2_O,
  output logic CARD_AUX_LINE_2_OE
);

  logic [`SYN_W-1:0] sync1_ff;
  logic [`SYN_W-1:0] sync2_ff;
  card_gate_pkg::supply_cmd_t cmd;
  logic selected;
  logic present;
  card_gate_pkg::seq_state_t state_ff;
  card_gate_pkg::seq_state_t nxt_state;
  logic nxt_active;
  card_gate_pkg::vcc_level_t level_ff;
  logic vcc_en_ff;
  logic ready_ff;
  logic act_ff;
  logic card_reset_ff;
  logic irq_ff;
  logic gsync1_ff;
  logic gsync2_ff;
  logic gate_ff;
  card_gate_pkg::od_drive_t host_drv [3];
  card_gate_pkg::od_drive_t card_drv [3];
  logic [2:0] host_in;
  logic [2:0] card_in;

  // Every pin input other than clocks and reset passes two flip-flops before use
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      sync1_ff <= `SYN_RESET_VAL;
      sync2_ff <= `SYN_RESET_VAL;
    end else begin
      sync1_ff <= {HOST_RESET_CMD, SUPPLY_SELECT_A_N, SUPPLY_SELECT_B_N,
                   CARD_PRESENCE_INPUT, CARD_PRESENCE_INPUT_N, VCC_GOOD};
      sync2_ff <= sync1_ff;
    end
  end

  assign cmd.sel_a_n = sync2_ff[`SYN_SEL_A_N];
  assign cmd.sel_b_n = sync2_ff[`SYN_SEL_B_N];
  assign selected = (cmd != `SEL_NONE);
  assign present = sync2_ff[`SYN_CARD_PRESENCE_INPUT] | ~sync2_ff[`SYN_CARD_PRESENCE_INPUT_N];

  // Supply sequencer: ramp on select, fault on loss of card or supply
  always_comb begin
    nxt_state = state_ff;
    unique case (state_ff)
      card_gate_pkg::SEQ_OFF: begin
        if (selected && present) begin
          nxt_state = card_gate_pkg::SEQ_RAMP;
        end
      end
      card_gate_pkg::SEQ_RAMP: begin
        if (!selected) begin
          nxt_state = card_gate_pkg::SEQ_OFF;
        end else if (!present) begin
          nxt_state = card_gate_pkg::SEQ_FAULT;
        end else if (sync2_ff[`SYN_VCC_OK]) begin
          nxt_state = card_gate_pkg::SEQ_ACTIVE;
        end
      end
      card_gate_pkg::SEQ_ACTIVE: begin
        if (!selected) begin
          nxt_state = card_gate_pkg::SEQ_OFF;
        end else if (!present || !sync2_ff[`SYN_VCC_OK]) begin
          nxt_state = card_gate_pkg::SEQ_FAULT;
        end
      end
      card_gate_pkg::SEQ_FAULT: begin
        if (!selected) begin
          nxt_state = card_gate_pkg::SEQ_OFF;
        end
      end
    endcase
  end

  assign nxt_active = (nxt_state == card_gate_pkg::SEQ_ACTIVE);

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      state_ff <= card_gate_pkg::SEQ_OFF;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // Supply switch follows the sequencer only
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      vcc_en_ff <= 1'h0;
    end else begin
      vcc_en_ff <= (nxt_state == card_gate_pkg::SEQ_RAMP) || nxt_active;
    end
  end

  // Level is captured at power-up of a session
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      level_ff <= card_gate_pkg::VCC_OFF;
    end else if (nxt_state == card_gate_pkg::SEQ_OFF ||
                 nxt_state == card_gate_pkg::SEQ_FAULT) begin
      level_ff <= card_gate_pkg::VCC_OFF;
    end else if (state_ff == card_gate_pkg::SEQ_OFF) begin
      level_ff <= card_gate_pkg::vcc_level_t'(cmd);
    end
  end

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      ready_ff <= 1'h0;
      act_ff <= 1'h0;
    end else begin
      ready_ff <= nxt_active;
      act_ff <= nxt_active;
    end
  end

  // Card reset contact
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      card_reset_ff <= 1'h0;
    end else if (nxt_active) begin
      card_reset_ff <= sync2_ff[`SYN_RESET_CMD];
    end else begin
      card_reset_ff <= 1'h0;
    end
  end

  // Interrupt pulled low while a card sits or a fault stands
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      irq_ff <= 1'h0;
    end else begin
      irq_ff <= present || (nxt_state == card_gate_pkg::SEQ_FAULT);
    end
  end

  // Clock gate enable crosses into the card clock domain
  always_ff @(posedge CARD_CLOCK_SOURCE or negedge RST_N) begin
    if (!RST_N) begin
      gsync1_ff <= 1'h0;
      gsync2_ff <= 1'h0;
    end else begin
      gsync1_ff <= act_ff;
      gsync2_ff <= gsync1_ff;
    end
  end

  // Enable changes while the source is low, so no runt pulses
  always_ff @(negedge CARD_CLOCK_SOURCE or negedge RST_N) begin
    if (!RST_N) begin
      gate_ff <= 1'h0;
    end else begin
      gate_ff <= gsync2_ff;
    end
  end

  // A stopped source cannot hold the gate open: act_ff closes it at once
  assign CARD_CLOCK = CARD_CLOCK_SOURCE & gate_ff & act_ff;

  assign host_in = {HOST_AUX_LINE_2_I, HOST_AUX_LINE_1_I, HOST_DATA_LINE_I};
  assign card_in = {CARD_AUX_LINE_2_I, CARD_AUX_LINE_1_I, CARD_DATA_LINE_I};

  // Data line and both aux lines relay only while the card is active
  for (genvar i = 0; i < 3; i++) begin : g_line
    card_line_relay u_relay (
      .clk(CLK),
      .rst_n(RST_N),
      .enable(act_ff),
      .host_i(host_in[i]),
      .card_i(card_in[i]),
      .host_drv(host_drv[i]),
      .card_drv(card_drv[i])
    );
  end

  assign VCC_ENABLE = vcc_en_ff;
  assign VCC_LEVEL = level_ff;
  assign READY = ready_ff;
  assign CARD_RESET = card_reset_ff;
  assign IRQ_N_O = 1'h0;
  assign IRQ_N_OE = irq_ff;
  assign HOST_DATA_LINE_O = host_drv[0].o;
  assign HOST_DATA_LINE_OE = host_drv[0].oe;
  assign CARD_DATA_LINE_O = card_drv[0].o;
  assign CARD_DATA_LINE_OE = card_drv[0].oe;
  assign HOST_AUX_LINE_1_O = host_drv[1].o;
  assign HOST_AUX_LINE_1_OE = host_drv[1].oe;
  assign CARD_AUX_LINE_1_O = card_drv[1].o;
  assign CARD_AUX_LINE_1_OE = card_drv[1].oe;
  assign HOST_AUX_LINE_2_O = host_drv[2].o;
  assign HOST_AUX_LINE_2_OE = host_drv[2].oe;
  assign CARD_AUX_LINE_2_O = card_drv[2].o;
  assign CARD_AUX_LINE_2_OE = card_drv[2].oe;

endmodule : card_signal_gating

// ### tb/card_gate_properties.sv
// Port-level checks for the card signal gating block
`timescale 1ns/100ps
module card_gate_properties (
  input wire logic CLK,
  input wire logic RST_N,
  input wire logic CARD_CLOCK_SOURCE,
  input wire logic HOST_RESET_CMD,
  input wire logic SUPPLY_SELECT_A_N,
  input wire logic SUPPLY_SELECT_B_N,
  input wire logic CARD_PRESENCE_INPUT,
  input wire logic CARD_PRESENCE_INPUT_N,
  input wire logic VCC_GOOD,
  input wire logic HOST_DATA_LINE_I,
  input wire logic VCC_ENABLE,
  input wire logic READY,
  input wire logic CARD_RESET,
  input wire logic CARD_CLOCK,
  input wire logic IRQ_N_OE,
  input wire logic HOST_DATA_LINE_OE,
  input wire logic CARD_DATA_LINE_OE
);
  logic [2:0] up_ff;
  logic up;
  default clocking @(posedge CLK); endclocking
  default disable iff (!RST_N);
  // Keeps past-value checks from looking into reset
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      up_ff <= 3'h0;
    end else if (up_ff != 3'h7) begin
      up_ff <= up_ff + 3'h1;
    end
  end
  assign up = (up_ff == 3'h7);
  // Cycles of READY high; the gate is open well before the count tops out
  logic [4:0] rdy_cnt_ff;
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      rdy_cnt_ff <= 5'h00;
    end else if (!READY) begin
      rdy_cnt_ff <= 5'h00;
    end else if (rdy_cnt_ff != 5'h1F) begin
      rdy_cnt_ff <= rdy_cnt_ff + 5'h01;
    end
  end
  a_clock_copy: assert property (READY && rdy_cnt_ff == 5'h1F |->
    CARD_CLOCK == CARD_CLOCK_SOURCE) else $error("clock not passed");
  a_reset_copy: assert property (up && READY && $past(READY) |->
    CARD_RESET == $past(HOST_RESET_CMD, 3)) else $error("reset copy");
  a_reset_low: assert property (!READY |-> !CARD_RESET)
    else $error("reset not held low");
  a_clock_low: assert property (!READY |-> !CARD_CLOCK)
    else $error("clock not held low");
  a_irq_card_presence_input: assert property (up && $past(CARD_PRESENCE_INPUT, 3)
    |-> IRQ_N_OE) else $error("presence high ignored");
  a_irq_card_presence_input_n: assert property (up && !$past(CARD_PRESENCE_INPUT_N, 3)
    |-> IRQ_N_OE) else $error("presence low ignored");
  a_supply_on_sel: assert property (up && $rose(VCC_ENABLE) |->
    !($past(SUPPLY_SELECT_A_N, 3) && $past(SUPPLY_SELECT_B_N, 3)))
    else $error("supply on without select");
  a_ready_good: assert property (up && READY |-> VCC_ENABLE &&
    $past(VCC_GOOD, 3)) else $error("ready without good supply");
  a_relay_idle: assert property (!READY && !$past(READY) |->
    !CARD_DATA_LINE_OE && !HOST_DATA_LINE_OE) else $error("relay active");
  a_relay_drive: assert property (up && $rose(CARD_DATA_LINE_OE) |->
    !$past(HOST_DATA_LINE_I, 3)) else $error("card line driven unasked");
  c_ready: cover property ($rose(READY));
  c_relay: cover property ($rose(CARD_DATA_LINE_OE));
  c_clock: cover property (READY && CARD_CLOCK);
endmodule : card_gate_properties

bind card_signal_gating card_gate_properties u_props (
  .CLK(CLK), .RST_N(RST_N), .CARD_CLOCK_SOURCE(CARD_CLOCK_SOURCE),
  .HOST_RESET_CMD(HOST_RESET_CMD),
  .SUPPLY_SELECT_A_N(SUPPLY_SELECT_A_N),
  .SUPPLY_SELECT_B_N(SUPPLY_SELECT_B_N),
  .CARD_PRESENCE_INPUT(CARD_PRESENCE_INPUT),
  .CARD_PRESENCE_INPUT_N(CARD_PRESENCE_INPUT_N), .VCC_GOOD(VCC_GOOD),
  .HOST_DATA_LINE_I(HOST_DATA_LINE_I), .VCC_ENABLE(VCC_ENABLE),
  .READY(READY), .CARD_RESET(CARD_RESET), .CARD_CLOCK(CARD_CLOCK),
  .IRQ_N_OE(IRQ_N_OE), .HOST_DATA_LINE_OE(HOST_DATA_LINE_OE),
  .CARD_DATA_LINE_OE(CARD_DATA_LINE_OE));

// ### tb/card_model.sv
// Card-side model: contact pull-ups, card drive, clock edge count
`timescale 1ns/100ps
module card_model (
  input wire logic card_clk,
  input wire logic [2:0] dev_oe,
  input wire logic [2:0] card_pull,
  output logic [2:0] contact,
  output int clk_edges
);
  // Contacts sit high on the pull-up unless either side pulls low
  assign contact = ~(dev_oe | card_pull);
  initial clk_edges = 0;
  always @(posedge card_clk) clk_edges++;
endmodule : card_model

// ### tb/card_signal_gating_tb_top.sv
// Self-checking bench for the card signal gating block
`timescale 1ns/100ps
module card_signal_gating_tb_top;
  typedef struct {
    logic a_n, b_n, en;
    card_gate_pkg::vcc_level_t lv;
  } row_t;
  logic CLK, RST_N, src, rcmd, sa_n, sb_n, card_presence_input, card_presence_input_n, good;
  logic ven, rdy, crst, cclk, irq_o, irq_oe;
  card_gate_pkg::vcc_level_t lvl;
  logic [2:0] h_pull, c_pull, h_o, h_oe, c_o, c_oe, h_w, c_w;
  int num_errors, cmp_count, edges, e0, i;
  row_t rows[4];
  assign h_w = ~(h_pull | h_oe);
  card_signal_gating uut (.CLK(CLK), .RST_N(RST_N),
    .CARD_CLOCK_SOURCE(src), .HOST_RESET_CMD(rcmd),
    .SUPPLY_SELECT_A_N(sa_n), .SUPPLY_SELECT_B_N(sb_n),
    .CARD_PRESENCE_INPUT(card_presence_input), .CARD_PRESENCE_INPUT_N(card_presence_input_n),
    .VCC_GOOD(good), .VCC_ENABLE(ven), .VCC_LEVEL(lvl), .READY(rdy),
    .CARD_RESET(crst), .CARD_CLOCK(cclk), .IRQ_N_O(irq_o),
    .IRQ_N_OE(irq_oe), .HOST_DATA_LINE_I(h_w[0]),
    .HOST_DATA_LINE_O(h_o[0]), .HOST_DATA_LINE_OE(h_oe[0]),
    .CARD_DATA_LINE_I(c_w[0]), .CARD_DATA_LINE_O(c_o[0]),
    .CARD_DATA_LINE_OE(c_oe[0]), .HOST_AUX_LINE_1_I(h_w[1]),
    .HOST_AUX_LINE_1_O(h_o[1]), .HOST_AUX_LINE_1_OE(h_oe[1]),
    .CARD_AUX_LINE_1_I(c_w[1]), .CARD_AUX_LINE_1_O(c_o[1]),
    .CARD_AUX_LINE_1_OE(c_oe[1]), .HOST_AUX_LINE_2_I(h_w[2]),
    .HOST_AUX_LINE_2_O(h_o[2]), .HOST_AUX_LINE_2_OE(h_oe[2]),
    .CARD_AUX_LINE_2_I(c_w[2]), .CARD_AUX_LINE_2_O(c_o[2]),
    .CARD_AUX_LINE_2_OE(c_oe[2]));
  card_model cm (.card_clk(cclk), .dev_oe(c_oe), .card_pull(c_pull),
    .contact(c_w), .clk_edges(edges));
  initial begin
    CLK = 1'b0;
    forever #5 CLK = ~CLK;
  end
  // Card clock source, 80 ns, offset from the system clock
  initial begin
    src = 1'b0;
    #3;
    forever #40 src = ~src;
  end
  task automatic cyc(int n);
    repeat (n) @(posedge CLK);
  endtask : cyc
  task automatic chk(string n, logic e, logic g);
    cmp_count++;
    if (e !== g) begin
      num_errors++;
      $display("MISMATCH %s exp %b got %b", n, e, g);
    end
  endtask : chk
  task automatic chk_lv(string n, card_gate_pkg::vcc_level_t e,
                        card_gate_pkg::vcc_level_t g);
    cmp_count++;
    if (e !== g) begin
      num_errors++;
      $display("MISMATCH %s exp %b got %b", n, e, g);
    end
  endtask : chk_lv
  task automatic end_sim();
    $display("compares %0d mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : end_sim
  initial begin
    {RST_N, rcmd, card_presence_input, good, sa_n, sb_n, card_presence_input_n} = 7'h07;
    {h_pull, c_pull} = 6'h00;
    rows[0] = '{1'b1, 1'b1, 1'b0, card_gate_pkg::VCC_OFF};
    rows[1] = '{1'b0, 1'b0, 1'b1, card_gate_pkg::VCC_1V8};
    rows[2] = '{1'b0, 1'b1, 1'b1, card_gate_pkg::VCC_5V0};
    rows[3] = '{1'b1, 1'b0, 1'b1, card_gate_pkg::VCC_3V0};
    cyc(12);
    chk_lv("lvl_rst", card_gate_pkg::VCC_OFF, lvl);
    chk("ven_rst", 1'b0, ven);
    RST_N <= 1'b1;
    card_presence_input <= 1'b1;
    rcmd <= 1'b1;
    cyc(6);
    chk("irq_card_presence_input", 1'b1, irq_oe);
    chk("irq_o", 1'b0, irq_o);
    $display("test reset done");
    for (i = 0; i < 4; i++) begin
      sa_n <= rows[i].a_n;
      sb_n <= rows[i].b_n;
      cyc(6);
      chk("ven", rows[i].en, ven);
      chk_lv("lvl", rows[i].lv, lvl);
      chk("rdy_nogood", 1'b0, rdy);
      chk("crst_gated", 1'b0, crst);
      {sa_n, sb_n} <= 2'h3;
      cyc(6);
    end
    $display("test select table done");
    sb_n <= 1'b0;
    cyc(6);
    good <= 1'b1;
    for (i = 0; i < 20 && rdy !== 1'b1; i++) cyc(1);
    chk("rdy_on", 1'b1, rdy);
    if (rdy !== 1'b1) end_sim();
    cyc(1);
    chk("crst_hi", 1'b1, crst);
    rcmd <= 1'b0;
    cyc(5);
    chk("crst_lo", 1'b0, crst);
    e0 = edges;
    cyc(60);
    chk("cclk_run", 1'b1, edges - e0 >= 3);
    chk("cclk_copy", src, cclk);
    $display("test activation done");
    for (i = 0; i < 3; i++) begin
      h_pull[i] <= 1'b1;
      cyc(5);
      chk("card_line", 1'b0, c_w[i]);
      chk("card_o", 1'b0, c_o[i]);
      h_pull[i] <= 1'b0;
      cyc(9);
      c_pull[i] <= 1'b1;
      cyc(5);
      chk("host_line", 1'b0, h_w[i]);
      chk("host_o", 1'b0, h_o[i]);
      c_pull[i] <= 1'b0;
      cyc(9);
      chk("card_idle", 1'b1, c_w[i]);
    end
    $display("test relays done");
    {card_presence_input, card_presence_input_n, rcmd} <= 3'h1;
    cyc(6);
    chk("irq_card_presence_input_n", 1'b1, irq_oe);
    chk("rdy_keep", 1'b1, rdy);
    chk("crst_hi2", 1'b1, crst);
    good <= 1'b0;
    cyc(6);
    chk("rdy_fault", 1'b0, rdy);
    chk("crst_fault", 1'b0, crst);
    chk("ven_fault", 1'b0, ven);
    e0 = edges;
    cyc(30);
    chk("cclk_stop", 1'b1, edges == e0);
    $display("test fault done");
    sb_n <= 1'b1;
    good <= 1'b1;
    cyc(6);
    chk("ven_off", 1'b0, ven);
    sb_n <= 1'b0;
    cyc(6);
    chk("rdy_again", 1'b1, rdy);
    chk_lv("lvl_again", card_gate_pkg::VCC_3V0, lvl);
    card_presence_input_n <= 1'b1;
    cyc(6);
    chk("rdy_removed", 1'b0, rdy);
    chk("ven_removed", 1'b0, ven);
    chk_lv("lvl_removed", card_gate_pkg::VCC_OFF, lvl);
    chk("irq_fault", 1'b1, irq_oe);
    sb_n <= 1'b1;
    cyc(6);
    chk("irq_clear", 1'b0, irq_oe);
    sa_n <= 1'b0;
    cyc(6);
    chk("ven_nocard", 1'b0, ven);
    $display("test removal done");
    end_sim();
  end
endmodule : card_signal_gating_tb_top
